// ==== gip_pkg.sv ====
// Constants and helpers shared by the indirect GPIO port block
package gip_pkg;

  // ****************************************************************
  // Register map (word indices, byte address is four times)
  // ****************************************************************
  localparam logic [13:0] IDX_SEL [4] = '{14'h0fd0, 14'h0fd4, 14'h0fd8, 14'h0fdc};
  localparam logic [13:0] IDX_WIN [4] = '{14'h0fd1, 14'h0fd5, 14'h0fd9, 14'h0fdd};
  localparam logic [13:0] IDX_IN  [4] = '{14'h0fd2, 14'h0fd6, 14'h0fda, 14'h0fde};
  localparam logic [13:0] IDX_OUT [4] = '{14'h0fd3, 14'h0fd7, 14'h0fdb, 14'h0fdf};
  localparam logic [13:0] IDX_IRQ_STAT = 14'h1000;
  localparam logic [13:0] IDX_IRQ_MASK = 14'h1001;
  localparam logic [13:0] IDX_IRQ_POL  = 14'h1002;

  // ****************************************************************
  // Subregister codes
  // ****************************************************************
  localparam logic [7:0] SUB_NONE  = 8'h00;
  localparam logic [7:0] SUB_DIR   = 8'h01;
  localparam logic [7:0] SUB_AF    = 8'h02;
  localparam logic [7:0] SUB_OD    = 8'h03;
  localparam logic [7:0] SUB_HDE   = 8'h04;
  localparam logic [7:0] SUB_WAKE  = 8'h05;
  localparam logic [7:0] SUB_PU    = 8'h06;
  localparam logic [7:0] SUB_AFS1  = 8'h07;
  localparam logic [7:0] SUB_AFS2  = 8'h08;
  localparam int         SUB_COUNT = 8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  SEL_RST      = 8'h00;
  localparam logic [7:0]  OUT_RST      = 8'h00;
  localparam logic [7:0]  DIR_RST      = 8'hff;
  localparam logic [7:0]  AF_RST_ABC   = 8'h00;
  localparam logic [7:0]  AF_RST_D     = 8'h01;
  localparam logic [7:0]  OD_RST_ABC   = 8'h00;
  localparam logic [7:0]  OD_RST_D     = 8'h01;
  localparam logic [7:0]  CFG_RST      = 8'h00;
  localparam logic [31:0] IRQ_RST      = 32'h0000_0000;
  localparam int          PORT_D       = 3;
  localparam int          SYNC_STAGES  = 3;

  // ****************************************************************
  // Bus answers
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Reset value of one subregister slot (slot = code minus one)
  function automatic logic [7:0] cfg_rst(input int port, input int slot);
    logic [7:0] v;
    v = CFG_RST;
    if (slot == int'(SUB_DIR) - 1) v = DIR_RST;
    if (slot == int'(SUB_AF) - 1)  v = (port == PORT_D) ? AF_RST_D : AF_RST_ABC;
    if (slot == int'(SUB_OD) - 1)  v = (port == PORT_D) ? OD_RST_D : OD_RST_ABC;
    return v;
  endfunction

  // Merge write data into a word by byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) v[8*b +: 8] = nw[8*b +: 8];
    end
    return v;
  endfunction

endpackage

// ==== gip_pin_port.sv ====
// Pad control and input conditioning for one 8-bit port
`timescale 1ns/1ps
module gip_pin_port #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Pin side
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] pin_o,
  output logic      [W-1:0] pin_oe,
  // Configuration
  input  wire logic [W-1:0] pin_output_value,
  input  wire logic [W-1:0] pin_direction,
  input  wire logic [W-1:0] altfunc_enable,
  input  wire logic [W-1:0] open_drain_select,
  input  wire logic [W-1:0] af_out,
  input  wire logic [W-1:0] af_oe,
  // Conditioned input
  output logic      [W-1:0] pin_input_value,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] sync_r [gip_pkg::SYNC_STAGES];
  logic [W-1:0] stable_r;
  logic [W-1:0] drv;
  logic [W-1:0] val;

  // Three-stage synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < gip_pkg::SYNC_STAGES; i++) sync_r[i] <= '0;
    end else begin
      sync_r[0] <= pin_i;
      for (int i = 1; i < gip_pkg::SYNC_STAGES; i++) sync_r[i] <= sync_r[i-1];
    end
  end

  // Accept a bit once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stable_r <= '0;
    end else begin
      for (int b = 0; b < W; b++) begin
        if (sync_r[1][b] == sync_r[2][b]) stable_r[b] <= sync_r[2][b];
      end
    end
  end

  // Edge pulses from the accepted value
  always_comb begin
    rise = (sync_r[1] & sync_r[2]) & ~stable_r;
    fall = ~(sync_r[1] | sync_r[2]) & stable_r;
  end
  assign pin_input_value = stable_r;

  // Drive source: alternate function or GPIO direction/data
  always_comb begin
    drv = (altfunc_enable & af_oe) | (~altfunc_enable & ~pin_direction);
    val = (altfunc_enable & af_out) | (~altfunc_enable & pin_output_value);
    pin_o  = val & ~open_drain_select;
    pin_oe = drv & ~(open_drain_select & val);
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_dir_drive: assert property (
    ~altfunc_enable[0] & ~pin_direction[0] & ~open_drain_select[0]
      |-> pin_oe[0] && pin_o[0] == pin_output_value[0])
    else $error("GPIO output bit not driven with output data");
  a_dir_input: assert property (~altfunc_enable[0] & pin_direction[0] |-> !pin_oe[0])
    else $error("Input pin is being driven");
  a_af_override: assert property (
    altfunc_enable[0] & ~open_drain_select[0] |-> pin_oe[0] == af_oe[0] && pin_o[0] == af_out[0])
    else $error("Alternate function does not control pin");
  a_od_release: assert property (open_drain_select[0] |-> !pin_o[0] && !(pin_oe[0] && val[0]))
    else $error("Open-drain pin drives high");
  a_input_settle: assert property (
    $changed(sync_r[2][0]) ##1 (sync_r[1][0] == sync_r[2][0]) [*2] |=> stable_r[0] == sync_r[2][0])
    else $error("Settled pin not accepted");

endmodule // gip_pin_port

// ==== gip_top.sv ====
// Four-port GPIO block with indirect configuration and AXI4-Lite registers
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module gip_top #(
  parameter logic [31:0] EDGE_CFG_PINS = 32'h0000_00ff
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Pins, four ports of eight, port A in the low byte
  input  wire logic [31:0] pin_i,
  output logic [31:0]      pin_o,
  output logic [31:0]      pin_oe,
  output logic [31:0]      pullup_select,
  output logic [31:0]      strong_drive_enable,
  output logic [31:0]      wake_source_enable,
  // Alternate function peripherals
  input  wire logic [31:0] af_out,
  input  wire logic [31:0] af_oe,
  output logic [31:0]      af_in,
  output logic [31:0]      altfunc_enable,
  output logic [31:0]      altfunc_choice_low,
  output logic [31:0]      altfunc_choice_high,
  // Interrupt
  output logic             irq
);

  logic [7:0]  sel_r [4];
  logic [7:0]  cfg_r [4][gip_pkg::SUB_COUNT];
  logic [7:0]  out_r [4];
  logic [31:0] stat_r;
  logic [31:0] mask_r;
  logic [31:0] pol_r;
  logic [31:0] in_val;
  logic [31:0] rise;
  logic [31:0] fall;
  logic [31:0] ev;
  logic [31:0] stat_clr;
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [15:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;
  logic        wr_do;
  logic        rd_do;
  logic [13:0] wi;
  logic [13:0] ri;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] rd_nxt;
  logic [3:0]  sel_ok;
  logic [2:0]  slot [4];

  // ****************************************************************
  // Per-port pad logic
  // ****************************************************************
  generate
    for (genvar p = 0; p < 4; p++) begin : g_port
      gip_pin_port #(.W(8)) u_port (
        .aclk              (aclk),
        .aresetn           (aresetn),
        .pin_i             (pin_i[8*p +: 8]),
        .pin_o             (pin_o[8*p +: 8]),
        .pin_oe            (pin_oe[8*p +: 8]),
        .pin_output_value  (out_r[p]),
        .pin_direction     (cfg_r[p][int'(gip_pkg::SUB_DIR) - 1]),
        .altfunc_enable    (cfg_r[p][int'(gip_pkg::SUB_AF) - 1]),
        .open_drain_select (cfg_r[p][int'(gip_pkg::SUB_OD) - 1]),
        .af_out            (af_out[8*p +: 8]),
        .af_oe             (af_oe[8*p +: 8]),
        .pin_input_value   (in_val[8*p +: 8]),
        .rise              (rise[8*p +: 8]),
        .fall              (fall[8*p +: 8])
      );
      // Configuration fields out to the pad ring and peripherals
      assign altfunc_enable[8*p +: 8]      = cfg_r[p][int'(gip_pkg::SUB_AF) - 1];
      assign strong_drive_enable[8*p +: 8] = cfg_r[p][int'(gip_pkg::SUB_HDE) - 1];
      assign wake_source_enable[8*p +: 8]  = cfg_r[p][int'(gip_pkg::SUB_WAKE) - 1];
      assign pullup_select[8*p +: 8]       = cfg_r[p][int'(gip_pkg::SUB_PU) - 1];
      assign altfunc_choice_low[8*p +: 8]  = cfg_r[p][int'(gip_pkg::SUB_AFS1) - 1];
      assign altfunc_choice_high[8*p +: 8] = cfg_r[p][int'(gip_pkg::SUB_AFS2) - 1];
      // Selector decode: only codes 01H..08H reach a slot
      assign sel_ok[p] = (sel_r[p] >= gip_pkg::SUB_DIR) && (sel_r[p] <= gip_pkg::SUB_AFS2);
      assign slot[p]   = 3'(sel_r[p][2:0] - 3'd1);
    end
  endgenerate
  assign af_in = in_val;

  // ****************************************************************
  // AXI4-Lite handshakes
  // ****************************************************************
  assign s_axi_awready = ~aw_hold_r;
  assign s_axi_wready  = ~w_hold_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign wr_do = aw_hold_r & w_hold_r & ~bvalid_r;
  assign rd_do = s_axi_arvalid & ~rvalid_r;
  assign wi    = awaddr_r[15:2];
  assign ri    = s_axi_araddr[15:2];

  // Capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 16'h0000;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_hold_r) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && !w_hold_r) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_do) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  // Write address decode
  always_comb begin
    wr_hit = (wi == gip_pkg::IDX_IRQ_STAT) || (wi == gip_pkg::IDX_IRQ_MASK) ||
             (wi == gip_pkg::IDX_IRQ_POL);
    for (int p = 0; p < 4; p++) begin
      if (wi == gip_pkg::IDX_SEL[p] || wi == gip_pkg::IDX_WIN[p] ||
          wi == gip_pkg::IDX_IN[p] || wi == gip_pkg::IDX_OUT[p]) wr_hit = 1'b1;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= gip_pkg::RESP_OKAY;
    end else if (wr_do) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? gip_pkg::RESP_OKAY : gip_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Port registers
  // ****************************************************************

  // Selectors and output data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < 4; p++) begin
        sel_r[p] <= gip_pkg::SEL_RST;
        out_r[p] <= gip_pkg::OUT_RST;
      end
    end else if (wr_do && wstrb_r[0]) begin
      for (int p = 0; p < 4; p++) begin
        if (wi == gip_pkg::IDX_SEL[p]) sel_r[p] <= wdata_r[7:0];
        if (wi == gip_pkg::IDX_OUT[p]) out_r[p] <= wdata_r[7:0];
      end
    end
  end

  // Window writes land in the selected subregister only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < 4; p++) begin
        for (int s = 0; s < gip_pkg::SUB_COUNT; s++) cfg_r[p][s] <= gip_pkg::cfg_rst(p, s);
      end
    end else if (wr_do && wstrb_r[0]) begin
      for (int p = 0; p < 4; p++) begin
        if (wi == gip_pkg::IDX_WIN[p] && sel_ok[p]) begin
          cfg_r[p][slot[p]] <= wdata_r[7:0];
        end
      end
    end
  end

  // ****************************************************************
  // Pin interrupts
  // ****************************************************************

  // Selectable pins use polarity (1 rising, 0 falling); others any edge
  always_comb begin
    ev = (EDGE_CFG_PINS & ((pol_r & rise) | (~pol_r & fall))) |
         (~EDGE_CFG_PINS & (rise | fall));
    stat_clr = (wr_do && wi == gip_pkg::IDX_IRQ_STAT) ?
               gip_pkg::merge(32'h0000_0000, wdata_r, wstrb_r) : 32'h0000_0000;
  end

  // Sticky status, set wins over write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) stat_r <= gip_pkg::IRQ_RST;
    else          stat_r <= (stat_r & ~stat_clr) | ev;
  end

  // Mask and polarity
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= gip_pkg::IRQ_RST;
      pol_r  <= gip_pkg::IRQ_RST;
    end else if (wr_do) begin
      if (wi == gip_pkg::IDX_IRQ_MASK) mask_r <= gip_pkg::merge(mask_r, wdata_r, wstrb_r);
      if (wi == gip_pkg::IDX_IRQ_POL)  pol_r  <= gip_pkg::merge(pol_r, wdata_r, wstrb_r);
    end
  end

  // Interrupt level
  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else          irq <= |(((stat_r & ~stat_clr) | ev) & mask_r);
  end

  // ****************************************************************
  // Read path
  // ****************************************************************

  // Read mux, window follows the selector
  always_comb begin
    rd_nxt = 32'h0000_0000;
    rd_hit = 1'b1;
    if (ri == gip_pkg::IDX_IRQ_STAT)      rd_nxt = stat_r;
    else if (ri == gip_pkg::IDX_IRQ_MASK) rd_nxt = mask_r;
    else if (ri == gip_pkg::IDX_IRQ_POL)  rd_nxt = pol_r;
    else rd_hit = 1'b0;
    for (int p = 0; p < 4; p++) begin
      if (ri == gip_pkg::IDX_SEL[p]) begin
        rd_hit = 1'b1;
        rd_nxt = {24'h00_0000, sel_r[p]};
      end
      if (ri == gip_pkg::IDX_WIN[p]) begin
        rd_hit = 1'b1;
        rd_nxt = sel_ok[p] ? {24'h00_0000, cfg_r[p][slot[p]]} : 32'h0000_0000;
      end
      if (ri == gip_pkg::IDX_IN[p]) begin
        rd_hit = 1'b1;
        rd_nxt = {24'h00_0000, in_val[8*p +: 8]};
      end
      if (ri == gip_pkg::IDX_OUT[p]) begin
        rd_hit = 1'b1;
        rd_nxt = {24'h00_0000, out_r[p]};
      end
    end
  end

  // Read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= gip_pkg::RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
    end else if (rd_do) begin
      rvalid_r <= 1'b1;
      rresp_r  <= rd_hit ? gip_pkg::RESP_OKAY : gip_pkg::RESP_SLVERR;
      rdata_r  <= rd_nxt;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_win_write_a;
    wr_do && wstrb_r[0] && wi == gip_pkg::IDX_WIN[0];
  endsequence

  sequence s_sel_a_code(logic [7:0] code);
    sel_r[0] == code;
  endsequence

  a_sel_reset: assert property ($rose(aresetn) |-> sel_r[0] == 8'h00 && sel_r[3] == 8'h00)
    else $error("Selector not zero after reset");
  a_win_dir: assert property (s_win_write_a and s_sel_a_code(8'h01)
    |=> cfg_r[0][0] == $past(wdata_r[7:0]))
    else $error("Direction not written through window");
  a_win_afs2: assert property (s_win_write_a and s_sel_a_code(8'h08)
    |=> cfg_r[0][7] == $past(wdata_r[7:0]) && $stable(cfg_r[0][6]))
    else $error("Altfunc choice high not written");
  a_unmapped_write: assert property (s_win_write_a and !sel_ok[0]
    |=> $stable(cfg_r[0][0]) && $stable(cfg_r[0][1]) && $stable(cfg_r[0][2]))
    else $error("Unmapped selector changed configuration");
  a_unmapped_read: assert property (rd_do && ri == gip_pkg::IDX_WIN[1] && !sel_ok[1]
    |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
    else $error("Unmapped window read not zero");
  a_edge_any: assert property ((rise[9] || fall[9]) && !EDGE_CFG_PINS[9]
    |=> stat_r[9] and (mask_r[9] && !stat_clr[9] |=> irq))
    else $error("Any-edge pin missed its event");
  a_edge_pol: assert property (EDGE_CFG_PINS[0] && fall[0] && pol_r[0] && !stat_r[0]
    && !rise[0] |=> !stat_r[0])
    else $error("Rising-only pin latched a falling edge");
  a_set_wins: assert property (ev[0] && stat_clr[0] |=> stat_r[0])
    else $error("Event lost against clear");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid)
    else $error("Write response late");

endmodule // gip_top

// ==== gip_pin_model.sv ====
// Pad model that resolves the 32 pin wires seen by the port block
`timescale 1ns/1ps
module gip_pin_model (
  // Clock
  input  wire logic        aclk,
  // Design drive
  input  wire logic [31:0] pin_o,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] pullup_select,
  // Bench drive
  input  wire logic [31:0] ext_val,
  input  wire logic [31:0] ext_oe,
  // Resolved wire
  output logic      [31:0] pin_i
);
  logic [31:0] last_r;

  // Last level, so an undriven line without pull-up wanders
  always_ff @(posedge aclk) begin
    last_r <= pin_i;
  end

  // Design drive first, then bench drive, then pull-up or wandering level
  always_comb begin
    pin_i = (pin_oe & pin_o) | (~pin_oe & ext_oe & ext_val)
          | (~pin_oe & ~ext_oe & (pullup_select | ~last_r));
  end
endmodule // gip_pin_model

// ==== tb_gpio_indirect_port_config.sv ====
// Self-checking bench for the indirect GPIO port block
`timescale 1ns/1ps
module tb_gpio_indirect_port_config;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp, rs;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v, ext_val, ext_oe, af_out, af_oe, seed, v;
  logic [31:0] pin_i, pin_o, pin_oe, pu, hd, wk, af_in, afe, afl, afh;
  logic [7:0]  m [4][9];
  logic [7:0]  bad [4];
  int          n_mismatch, tests_run, cyc;

  gip_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .pullup_select(pu), .strong_drive_enable(hd), .wake_source_enable(wk),
    .af_out(af_out), .af_oe(af_oe), .af_in(af_in), .altfunc_enable(afe),
    .altfunc_choice_low(afl), .altfunc_choice_high(afh), .irq(irq));

  gip_pin_model pads (.aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe),
    .pullup_select(pu), .ext_val(ext_val), .ext_oe(ext_oe), .pin_i(pin_i));

  // ******************
  // Helpers
  // ******************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Subregister reset values: direction all inputs, port D bit 0 altfunc open-drain
  function automatic logic [7:0] rst_v(int p, int c);
    if (c == 1) return 8'hff;
    if (p == 3 && (c == 2 || c == 3)) return 8'h01;
    return 8'h00;
  endfunction

  function automatic logic [31:0] cat(int c);
    return {m[3][c], m[2][c], m[1][c], m[0][c]};
  endfunction

  function automatic logic [15:0] sa(int p);
    return 16'h3f40 + 16'(p * 16);
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Write with address and data offered together; ready seen before the edge
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic ad, dd, bd;
    bd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!bd) begin
      @(negedge aclk);
      ad = awvalid & awready;
      dd = wvalid & wready;
      bd = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ad) awvalid <= 1'h0;
      if (dd) wvalid <= 1'h0;
    end
  endtask

  task automatic rd(input logic [15:0] a);
    logic gd, rdn;
    rdn = 0;
    araddr <= a;
    arvalid <= 1'h1;
    while (!rdn) begin
      @(negedge aclk);
      gd = arvalid & arready;
      rdn = rvalid;
      rd_v = rdata;
      rs = rresp;
      @(posedge aclk);
      if (gd) arvalid <= 1'h0;
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Clock at 100 MHz
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end

  // Watchdog against a hung handshake
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      close_out();
    end
  end

  // ******************
  // Sequence
  // ******************
  initial begin
    seed = 32'h6e75;
    {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata, ext_val} = '0;
    bready = 1'h1;
    rready = 1'h1;
    ext_oe = 32'hffff_ffff;
    af_out = rnd();
    af_oe = rnd();
    bad = '{8'h00, 8'h09, 8'hff, 8'h80};
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(16'h0000);
    chk(32'(rs), 32'h0000_0002);
    wr(16'h0000, rnd());
    chk(32'(rs), 32'h0000_0002);
    // Edge interrupts: pin 0 rising only, pin 8 any edge
    wr(16'h4004, 32'hffff_ffff);
    chk(32'(rs), 32'h0000_0000);
    wr(16'h4008, 32'h0000_0001);
    wr(16'h4000, 32'hffff_ffff);
    ext_val <= 32'h0000_0101;
    repeat (8) @(posedge aclk);
    rd(16'h4000);
    chk(rd_v, 32'h0000_0101);
    chk(32'(irq), 32'h0000_0001);
    wr(16'h4000, 32'hffff_ffff);
    ext_val <= 32'h0000_0000;
    repeat (8) @(posedge aclk);
    rd(16'h4000);
    chk(rd_v, 32'h0000_0100);
    wr(16'h4004, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0000_0000);
    // Pin 0 switched to falling edge: rising ignored, falling latched
    wr(16'h4008, 32'h0000_0000);
    wr(16'h4000, 32'hffff_ffff);
    ext_val <= 32'h0000_0001;
    repeat (8) @(posedge aclk);
    rd(16'h4000);
    chk(rd_v, 32'h0000_0000);
    ext_val <= 32'h0000_0000;
    repeat (8) @(posedge aclk);
    rd(16'h4000);
    chk(rd_v, 32'h0000_0001);
    // Every subregister of every port through its window
    for (int p = 0; p < 4; p++) begin
      rd(sa(p));
      chk(rd_v, 32'h0000_0000);
      rd(sa(p) + 4);
      chk(rd_v, 32'h0000_0000);
      for (int c = 1; c < 9; c++) begin
        wr(sa(p), 32'(c));
        rd(sa(p) + 4);
        chk(rd_v, 32'(rst_v(p, c)));
        m[p][c] = 8'(rnd());
        wr(sa(p) + 4, 32'(m[p][c]));
        rd(sa(p) + 4);
        chk(rd_v, 32'(m[p][c]));
      end
    end
    chk(afe, cat(2));
    chk(hd, cat(4));
    chk(wk, cat(5));
    chk(pu, cat(6));
    chk(afl, cat(7));
    chk(afh, cat(8));
    // Unmapped codes must not reach any subregister
    for (int p = 0; p < 4; p++) begin
      wr(sa(p), 32'(bad[p]));
      rd(sa(p));
      chk(rd_v, 32'(bad[p]));
      wr(sa(p) + 4, rnd());
      rd(sa(p) + 4);
      chk(rd_v, 32'h0000_0000);
      rd(sa(p) + 8);
      chk(rd_v, 32'(pin_i[8*p +: 8]));
      chk(32'(rs), 32'h0000_0000);
    end
    chk(af_in, pin_i);
    for (int p = 0; p < 4; p++) begin
      for (int c = 1; c < 9; c++) begin
        wr(sa(p), 32'(c));
        rd(sa(p) + 4);
        chk(rd_v, 32'(m[p][c]));
      end
    end
    // Port A pad control: outputs, then altfunc nibble, then open-drain
    for (int c = 1; c < 4; c++) begin
      wr(sa(0), 32'(c));
      wr(sa(0) + 4, 32'h0000_0000);
    end
    v = rnd();
    wr(16'h3f4c, v);
    chk(32'(pin_oe[7:0]), 32'h0000_00ff);
    chk(32'(pin_o[7:0]), 32'(v[7:0]));
    rd(16'h3f4c);
    chk(rd_v, 32'(v[7:0]));
    wr(sa(0), 32'h0000_0002);
    wr(sa(0) + 4, 32'h0000_000f);
    chk(32'(pin_oe[7:0]), 32'({4'hf, af_oe[3:0]}));
    chk(32'(pin_o[7:0]), 32'({v[7:4], af_out[3:0]}));
    wr(sa(0), 32'h0000_0003);
    wr(sa(0) + 4, 32'h0000_00ff);
    chk(32'(pin_o[7:0]), 32'h0000_0000);
    chk(32'(pin_oe[7:0]), 32'({4'hf, af_oe[3:0]} & ~{v[7:4], af_out[3:0]}));
    close_out();
  end
endmodule // tb_gpio_indirect_port_config
